// File: rtl/capture_compare_value_access.sv
// Capture/compare and auto-reload value registers of six counter-array modules
`timescale 1ns/1ns
`include "cc_value_consts.svh"
module capture_compare_value_access #(
	parameter int NUM_MODULES = `CC_NUM_MODULES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Special function register bus
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_page,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata_r,
	output logic sfr_hit_r,
	// Bits held in the mode and PWM configuration registers
	input wire logic reload_select,
	input wire logic [1:0] pwm_res,
	input wire logic [NUM_MODULES-1:0] wide_pwm_select,
	input wire logic [NUM_MODULES-1:0] pwm_function_enable,
	input wire logic [NUM_MODULES-1:0] mode_wr,
	input wire logic [NUM_MODULES-1:0] mode_comparator_enable,
	// Counter
	input wire logic [15:0] count,
	// Module state
	output logic [NUM_MODULES-1:0] comparator_function_enable_r,
	output logic [NUM_MODULES-1:0] module_output_pin_r
);
	cc_value_pkg::value_t capture_compare_value_r [NUM_MODULES];
	cc_value_pkg::value_t reload_value_r [NUM_MODULES];
	logic dec_hit;
	logic dec_high;
	cc_value_pkg::index_t dec_idx;
	logic wr_hit;

	// Returns {hit, high byte, module index}
	function automatic logic [4:0] decode(input logic [7:0] addr);
		case (addr)
			`CC_LOW_M0: decode = {2'b10, 3'd0};
			`CC_HIGH_M0: decode = {2'b11, 3'd0};
			`CC_LOW_M1: decode = {2'b10, 3'd1};
			`CC_HIGH_M1: decode = {2'b11, 3'd1};
			`CC_LOW_M2: decode = {2'b10, 3'd2};
			`CC_HIGH_M2: decode = {2'b11, 3'd2};
			`CC_LOW_M3: decode = {2'b10, 3'd3};
			`CC_HIGH_M3: decode = {2'b11, 3'd3};
			`CC_LOW_M4: decode = {2'b10, 3'd4};
			`CC_HIGH_M4: decode = {2'b11, 3'd4};
			`CC_LOW_M5: decode = {2'b10, 3'd5};
			`CC_HIGH_M5: decode = {2'b11, 3'd5};
			default: decode = 5'b0_0000;
		endcase
	endfunction

	// End of one 9-, 10- or 11-bit PWM period, where the reload value is taken over; never flagged at 8 bits
	function automatic logic rollover(input logic [15:0] cnt, input logic [1:0] res);
		case (res)
			2'b01: rollover = (cnt[8:0] == 9'h1ff);
			2'b10: rollover = (cnt[9:0] == 10'h3ff);
			2'b11: rollover = (cnt[10:0] == 11'h7ff);
			default: rollover = 1'b0;
		endcase
	endfunction

	always_comb
	begin
		{dec_hit, dec_high, dec_idx} = decode(sfr_addr);
		dec_hit = dec_hit && (sfr_page == `CC_PAGE_MAIN);
	end

	assign wr_hit = sfr_wr && dec_hit;

	// Value storage; a capture value write takes priority over a hardware reload
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < NUM_MODULES; i++)
			begin
				capture_compare_value_r[i] <= `CC_VALUE_RESET;
				reload_value_r[i] <= `CC_VALUE_RESET;
			end
		end
		else
		begin
			for (int i = 0; i < NUM_MODULES; i++)
			begin
				if (wr_hit && dec_idx == 3'(i) && reload_select)
				begin
					if (dec_high)
						reload_value_r[i][15:8] <= sfr_wdata;
					else
						reload_value_r[i][7:0] <= sfr_wdata;
				end
				if (wr_hit && dec_idx == 3'(i) && !reload_select)
				begin
					if (dec_high)
						capture_compare_value_r[i][15:8] <= sfr_wdata;
					else
						capture_compare_value_r[i][7:0] <= sfr_wdata;
				end
				else if (pwm_function_enable[i] && !wide_pwm_select[i] && rollover(count, pwm_res))
					capture_compare_value_r[i] <= reload_value_r[i];
			end
		end
	end

	// A value write overrides a same-cycle mode register write of the enable
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			comparator_function_enable_r <= '0;
		else
		begin
			for (int i = 0; i < NUM_MODULES; i++)
			begin
				if (wr_hit && dec_idx == 3'(i))
					comparator_function_enable_r[i] <= dec_high;
				else if (mode_wr[i])
					comparator_function_enable_r[i] <= mode_comparator_enable[i];
			end
		end
	end

	// Read data, one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sfr_rdata_r <= `CC_BYTE_RESET;
			sfr_hit_r <= 1'b0;
		end
		else
		begin
			sfr_hit_r <= sfr_rd && dec_hit;
			sfr_rdata_r <= `CC_BYTE_RESET;
			if (sfr_rd && dec_hit)
			begin
				if (reload_select)
					sfr_rdata_r <= dec_high ? reload_value_r[dec_idx][15:8]
						: reload_value_r[dec_idx][7:0];
				else
					sfr_rdata_r <= dec_high ? capture_compare_value_r[dec_idx][15:8]
						: capture_compare_value_r[dec_idx][7:0];
			end
		end
	end

	for (genvar g = 0; g < NUM_MODULES; g++)
	begin : g_pwm
		pwm_channel u_pwm (
			.clk_sys(clk_sys),
			.rst(rst),
			.pwm_function_enable(pwm_function_enable[g]),
			.wide_pwm_select(wide_pwm_select[g]),
			.pwm_res(cc_value_pkg::pwm_res_e'(pwm_res)),
			.count(count),
			.duty(capture_compare_value_r[g]),
			.module_output_pin_r(module_output_pin_r[g])
		);
	end

	// Assertions
	sequence low_write_s;
		sfr_wr && sfr_page == `CC_PAGE_MAIN && sfr_addr == `CC_LOW_M0;
	endsequence
	sequence high_write_s;
		sfr_wr && sfr_page == `CC_PAGE_MAIN && sfr_addr == `CC_HIGH_M0;
	endsequence

	low_clears_enable_a: assert property (@(posedge clk_sys) disable iff (rst)
		low_write_s |=> !comparator_function_enable_r[0])
		else $error("low byte write did not clear comparator enable");
	high_sets_enable_a: assert property (@(posedge clk_sys) disable iff (rst)
		high_write_s |=> comparator_function_enable_r[0])
		else $error("high byte write did not set comparator enable");
	low_write_read_a: assert property (@(posedge clk_sys) disable iff (rst)
		(low_write_s and !reload_select) ##1 (sfr_rd && sfr_addr == `CC_LOW_M0
		&& sfr_page == `CC_PAGE_MAIN && !reload_select && !pwm_function_enable[0])
		|=> sfr_hit_r && sfr_rdata_r == $past(sfr_wdata, 2))
		else $error("low byte readback mismatch");
	high_byte_store_a: assert property (@(posedge clk_sys) disable iff (rst)
		high_write_s and !reload_select
		|=> capture_compare_value_r[0][15:8] == $past(sfr_wdata))
		else $error("high byte not stored");
	reload_steer_a: assert property (@(posedge clk_sys) disable iff (rst)
		high_write_s and reload_select && !pwm_function_enable[0]
		|=> reload_value_r[0][15:8] == $past(sfr_wdata)
		&& $stable(capture_compare_value_r[0][15:8]))
		else $error("reload select did not steer the write");
	page_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
		sfr_rd && sfr_page != `CC_PAGE_MAIN |=> !sfr_hit_r && sfr_rdata_r == 8'h00)
		else $error("access decoded off page zero");
	pwm_off_low_a: assert property (@(posedge clk_sys) disable iff (rst)
		!pwm_function_enable[0] [*2] |-> !module_output_pin_r[0])
		else $error("pin active with PWM disabled");
	reset_clear_a: assert property (@(posedge clk_sys)
		$fell(rst) |-> capture_compare_value_r[0] == 16'h0000 && reload_value_r[0] == 16'h0000)
		else $error("values not cleared by reset");

	// A capture write of the same module in that cycle would win over the reload
	sequence reload_take_s;
		pwm_function_enable[0] && !wide_pwm_select[0] && rollover(count, pwm_res)
		&& !(wr_hit && !reload_select && dec_idx == 3'd0);
	endsequence
	reload_take_a: assert property (@(posedge clk_sys) disable iff (rst)
		reload_take_s |=> capture_compare_value_r[0] == $past(reload_value_r[0]))
		else $error("reload value not taken at the end of a period");
	pin_wide_a: assert property (@(posedge clk_sys) disable iff (rst)
		pwm_function_enable[0] && wide_pwm_select[0]
		|=> module_output_pin_r[0] == ($past(count) < $past(capture_compare_value_r[0])))
		else $error("wide PWM pin does not follow the compare");
	read_stands_a: assert property (@(posedge clk_sys) disable iff (rst)
		!sfr_rd |=> !sfr_hit_r && sfr_rdata_r == 8'h00)
		else $error("read answer without a read strobe");
endmodule

// File: rtl/cc_value_consts.svh
// Addresses, page and reset values of the capture/compare byte registers
`ifndef CC_VALUE_CONSTS_SVH
`define CC_VALUE_CONSTS_SVH
`define CC_PAGE_MAIN 8'h00
`define CC_LOW_M0 8'hfb
`define CC_HIGH_M0 8'hfc
`define CC_LOW_M1 8'he9
`define CC_HIGH_M1 8'hea
`define CC_LOW_M2 8'heb
`define CC_HIGH_M2 8'hec
`define CC_LOW_M3 8'hed
`define CC_HIGH_M3 8'hee
`define CC_LOW_M4 8'hfd
`define CC_HIGH_M4 8'hfe
`define CC_LOW_M5 8'hce
`define CC_HIGH_M5 8'hcf
`define CC_BYTE_RESET 8'h00
`define CC_VALUE_RESET 16'h0000
`define CC_NUM_MODULES 6
`define CC_READ_LATENCY 1
`endif

// File: rtl/cc_value_pkg.sv
// Types shared by the capture/compare value block
package cc_value_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] value_t;
	typedef logic [2:0] index_t;
	// Narrow PWM resolution chosen by the configuration register
	typedef enum logic [1:0] {
		RES_8 = 2'b00,
		RES_9 = 2'b01,
		RES_10 = 2'b10,
		RES_11 = 2'b11
	} pwm_res_e;
endpackage

// File: rtl/pwm_channel.sv
// One PWM output of a capture/compare module
`timescale 1ns/1ns
module pwm_channel (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Mode
	input wire logic pwm_function_enable,
	input wire logic wide_pwm_select,
	input wire cc_value_pkg::pwm_res_e pwm_res,
	// Counter and duty value
	input wire cc_value_pkg::value_t count,
	input wire cc_value_pkg::value_t duty,
	// Pin
	output logic module_output_pin_r
);
	cc_value_pkg::value_t mask;

	always_comb
	begin
		mask = 16'h00ff;
		case (pwm_res)
			cc_value_pkg::RES_9: mask = 16'h01ff;
			cc_value_pkg::RES_10: mask = 16'h03ff;
			cc_value_pkg::RES_11: mask = 16'h07ff;
			default: mask = 16'h00ff;
		endcase
		if (wide_pwm_select)
			mask = 16'hffff;
	end

	// High while the counter is below the duty value, compared at the chosen width
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			module_output_pin_r <= 1'b0;
		else
			module_output_pin_r <= pwm_function_enable && ((count & mask) < (duty & mask));
	end
endmodule

// File: test/sfr_core_model.sv
// Processor core model issuing register bus cycles
`timescale 1ns/1ns
module sfr_core_model (
	// Clock
	input wire logic clk_sys,
	// Register bus
	output logic [7:0] sfr_addr,
	output logic [7:0] sfr_page,
	output logic sfr_wr,
	output logic sfr_rd,
	output logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata_r,
	input wire logic sfr_hit_r
);
	initial
	begin
		sfr_addr = 8'h00;
		sfr_page = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
	end
	// Idle address and data are inverted so a stale value never passes as valid
	task automatic cycle(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d,
		input logic w);
		@(negedge clk_sys);
		sfr_page = p;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = w;
		sfr_rd = !w;
		@(negedge clk_sys);
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = ~a;
		sfr_wdata = ~d;
	endtask
	// Write on page zero, then read the same address at the very next edge
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
		@(negedge clk_sys);
		sfr_page = 8'h00;
		sfr_addr = a;
		sfr_wdata = wd;
		sfr_wr = 1'b1;
		@(negedge clk_sys);
		sfr_wr = 1'b0;
		sfr_rd = 1'b1;
		@(negedge clk_sys);
		sfr_rd = 1'b0;
		sfr_addr = ~a;
		sfr_wdata = ~wd;
		d = sfr_rdata_r;
	endtask
	task automatic rd(input logic [7:0] p, input logic [7:0] a, output logic [7:0] d,
		output logic h);
		cycle(p, a, 8'h00, 1'b0);
		d = sfr_rdata_r;
		h = sfr_hit_r;
	endtask
endmodule

// File: test/tb.sv
// Testbench for the capture/compare value registers
`timescale 1ns/1ns
`include "cc_value_consts.svh"
module tb;
	logic clk_sys;
	logic rst;
	logic reload_select;
	logic [1:0] pwm_res;
	logic [5:0] wide_pwm_select;
	logic [5:0] pwm_function_enable;
	logic [5:0] mode_wr;
	logic [5:0] mode_comparator_enable;
	logic [15:0] count;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_page;
	logic sfr_wr;
	logic sfr_rd;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata_r;
	logic sfr_hit_r;
	logic [5:0] comparator_function_enable_r;
	logic [5:0] module_output_pin_r;
	logic [7:0] lo [6] = '{`CC_LOW_M0, `CC_LOW_M1, `CC_LOW_M2, `CC_LOW_M3, `CC_LOW_M4, `CC_LOW_M5};
	logic [7:0] hi [6] = '{`CC_HIGH_M0, `CC_HIGH_M1, `CC_HIGH_M2, `CC_HIGH_M3, `CC_HIGH_M4,
		`CC_HIGH_M5};
	int fail_count = 0;
	int check_count = 0;
	int m;
	logic [7:0] k;
	logic [5:0] en;
	logic [7:0] rb;
	capture_compare_value_access #(.NUM_MODULES(6)) i_dut (.clk_sys, .rst, .sfr_addr, .sfr_page,
		.sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_r, .sfr_hit_r, .reload_select, .pwm_res,
		.wide_pwm_select, .pwm_function_enable, .mode_wr, .mode_comparator_enable, .count,
		.comparator_function_enable_r, .module_output_pin_r);
	sfr_core_model i_core (.clk_sys, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata,
		.sfr_rdata_r, .sfr_hit_r);
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] exp, input logic hit,
		input logic [7:0] p = 8'h00);
		logic [7:0] d;
		logic h;
		i_core.rd(p, a, d, h);
		check("read data", {8'h00, exp}, {8'h00, d});
		check("read hit", {15'h0000, hit}, {15'h0000, h});
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Every wait below is a fixed count, so a hang can only come from a stuck task
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		fail_count++;
		report_and_stop();
	end
	initial
	begin
		rst = 1'b1;
		reload_select = 1'b0;
		pwm_res = 2'b00;
		wide_pwm_select = 6'h00;
		pwm_function_enable = 6'h00;
		mode_wr = 6'h00;
		mode_comparator_enable = 6'h00;
		count = 16'h0000;
		repeat (6) @(negedge clk_sys);
		rst = 1'b0;
		for (m = 0; m < 6; m++)
		begin
			rc(lo[m], 8'h00, 1'b1);
			rc(hi[m], 8'h00, 1'b1);
		end
		// All enables set first, so a clear on a low write can show
		mode_comparator_enable = 6'h3f;
		mode_wr = 6'h3f;
		@(negedge clk_sys);
		mode_wr = 6'h00;
		en = 6'h3f;
		for (m = 0; m < 6; m++)
		begin
			k = 8'(m);
			i_core.cycle(8'h00, lo[m], 8'h50 + k, 1'b1);
			en[m] = 1'b0;
			check("enable", {10'h000, en}, {10'h000, comparator_function_enable_r});
			i_core.cycle(8'h00, hi[m], 8'ha0 + k, 1'b1);
			en[m] = 1'b1;
			check("enable", {10'h000, en}, {10'h000, comparator_function_enable_r});
		end
		i_core.cycle(8'h01, lo[0], 8'hee, 1'b1);
		rc(lo[0], 8'h00, 1'b0, 8'h01);
		rc(8'hf9, 8'h00, 1'b0);
		reload_select = 1'b1;
		for (m = 0; m < 6; m++)
		begin
			k = 8'(m);
			rc(lo[m], 8'h00, 1'b1);
			i_core.cycle(8'h00, lo[m], 8'h30 + k, 1'b1);
			i_core.cycle(8'h00, hi[m], 8'hc0 + k, 1'b1);
			rc(hi[m], 8'hc0 + k, 1'b1);
		end
		reload_select = 1'b0;
		for (m = 0; m < 6; m++)
		begin
			k = 8'(m);
			rc(lo[m], 8'h50 + k, 1'b1);
			rc(hi[m], 8'ha0 + k, 1'b1);
		end
		// Write and read back to back, with no idle cycle between
		i_core.wr_rd(lo[0], 8'h5a, rb);
		check("back to back", 16'h005a, {8'h00, rb});
		// Module 0 at 16 bits holds 0xa05a, so the pin follows count against it
		wide_pwm_select = 6'h01;
		pwm_function_enable = 6'h01;
		repeat (2) @(negedge clk_sys);
		check("pin", 16'h0001, {10'h000, module_output_pin_r});
		count = 16'hffff;
		repeat (2) @(negedge clk_sys);
		check("pin", 16'h0000, {10'h000, module_output_pin_r});
		// At 9 bits module 0 takes its reload value 0xc030 whenever the count wraps
		wide_pwm_select = 6'h00;
		pwm_res = 2'b01;
		repeat (2) @(negedge clk_sys);
		count = 16'hfe10;
		repeat (2) @(negedge clk_sys);
		check("pin", 16'h0001, {10'h000, module_output_pin_r});
		rc(lo[0], 8'h30, 1'b1);
		rc(hi[0], 8'hc0, 1'b1);
		report_and_stop();
	end
endmodule
